// File: cag_pkg.sv
// constants, types and shared encodings for the cpu address generator and exception sequencer
// assumes a single 25 MHz bus clock; opcode decode happens upstream of this block
// What this block does
// RULE1: every operand access uses a 16-bit address in one flat 64 KB space.
// RULE2: for bit-test, compare and decrement branches, mode locates operand; target uses branch offset.
// RULE3: register-only mode reads no memory for operands.
// RULE4: branch offset is a signed byte, sign-extended and added to pc when taken.
// RULE5: literal operand follows opcode; 16-bit literal upper byte first.
// RULE6: page-zero address is zero upper byte plus instruction byte.
// RULE7: full-address mode takes 16-bit address from next two bytes, upper first.
// RULE8: indexed no-offset uses the index pair directly.
// RULE9: post-increment indexed modes add one to index pair after the operand fetch.
// RULE10: index byte offset mode adds unsigned byte offset to index pair.
// RULE11: index word offset mode adds 16-bit offset to index pair.
// RULE12: stack byte offset mode adds unsigned byte offset to stack pointer.
// RULE13: stack word offset mode adds 16-bit offset to stack pointer.
// RULE14: any reset abandons current activity at once.
// RULE15: after reset, six-cycle sequence fetches vector from top two addresses and fills queue.
// RULE16: interrupt waits for instruction end; vector from highest request pending at sequence start.
// RULE17: push pcl, pch, x, a, flags; set mask; read vector; idle; prefetch three bytes.
// RULE18: upper index byte is not stacked; service software saves it itself.
// RULE19: software trap stacks like an interrupt, ignores mask, in step with program.
// RULE20: doze clears mask, gates clocks; interrupt, reset or debug-halt command wakes.
// RULE21: halt with debug host and enable keeps oscillator; debug-halt command wakes to debug.
// RULE22: debug-halt opcode enters debug; only reset, resume, step or tagged resume leave.
// RULE23: stack pointer reset to top of first 256-byte page.
// RULE24: no interrupt at the boundary right after an instruction clears a set mask.
// RULE25: indexed sums and post-increments wrap modulo 16 bits.
package cag_pkg;
    typedef enum logic [3:0] {
        register_only_mode,
        branch_offset_mode,
        literal_operand_mode,
        page_zero_mode,
        full_address_mode,
        index_no_offset_mode,
        index_postinc_mode,
        index_byte_offset_mode,
        index_byte_offset_postinc_mode,
        index_word_offset_mode,
        stack_byte_offset_mode,
        stack_word_offset_mode
    } cag_mode_type;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_DEBUG_HALT,
        CMD_RESUME,
        CMD_SINGLE_STEP,
        CMD_TAGGED_RESUME
    } cag_dbg_cmd_type;

    typedef enum logic [1:0] {
        LP_RUN,
        LP_DOZE,
        LP_HALT
    } cag_lowpower_type;

    localparam logic [15:0] RESET_VECTOR_HI  = 16'hfffe;
    localparam logic [15:0] RESET_VECTOR_LO  = 16'hffff;
    localparam logic [15:0] STACK_RESET      = 16'h00ff;
    localparam logic [7:0]  PAGE_ZERO_HI     = 8'h00;
    localparam logic [15:0] INDEX_STEP       = 16'h0001;
    localparam logic [7:0]  FLAGS_RESET      = 8'h68;
    localparam int          MASK_BIT         = 3;
    localparam int          RESET_SEQ_CYCLES = 6;
    localparam int          PREFETCH_BYTES   = 3;
endpackage

// File: cag_core.sv
// effective-address generator and special-sequence engine of the cpu core
// assumes upstream decode supplies mode, operand bytes and start strobes; memory answers in one cycle
`timescale 1ns/1ns
module cag_core (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     eaStart,
    input  wire cag_pkg::cag_mode_type    eaMode,
    input  wire logic [7:0]               operandHi,
    input  wire logic [7:0]               operandLo,
    input  wire logic                     branchTaken,
    input  wire logic                     instrBoundary,
    input  wire logic                     irqPending,
    input  wire logic [15:0]              irqVectorAddr,
    input  wire logic                     trapOp,
    input  wire logic                     dozeOp,
    input  wire logic                     haltOp,
    input  wire logic                     debugHaltOp,
    input  wire logic                     maskClearOp,
    input  wire logic                     debugHostAttached,
    input  wire logic                     debug_enable_bit,
    input  wire cag_pkg::cag_dbg_cmd_type dbgCmd,
    input  wire logic [7:0]               accIn,
    input  wire logic [7:0]               memRdata,
    output logic [15:0]                   memAddr,
    output logic                          memRead,
    output logic                          memWrite,
    output logic [7:0]                    memWdata,
    output logic [15:0]                   operandAddr,
    output logic                          operandValid,
    output logic                          operandNoMem,
    output logic [15:0]                   literalWord,
    output logic [15:0]                   programCounter,
    output logic [15:0]                   stack_pointer,
    output logic [15:0]                   indexPair,
    output logic [7:0]                    flag_register,
    output logic                          cpuClockEnable,
    output logic                          oscKeepAlive,
    output logic                          debugActive,
    output logic                          seqBusy
);
    import cag_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_RST, S_PUSH, S_VEC_HI, S_VEC_LO, S_FREE, S_FETCH
    } cag_seq_type;

    cag_seq_type       seqState_reg;
    logic [2:0]        stepCnt_reg;
    logic [15:0]       vecAddr_reg;
    logic [15:0]       pc_reg;
    logic [15:0]       sp_reg;
    logic [15:0]       ix_reg;
    logic [7:0]        flags_reg;
    logic [7:0]        vecHi_reg;
    cag_lowpower_type  lp_reg;
    logic              dbg_reg;
    logic              irqBlock_reg;
    logic [15:0]       eaNext;
    logic              postInc;
    logic              irqTake;
    logic              wake;

    // sums modulo 16 bits wrap naturally by keeping 16-bit targets
    function automatic logic [15:0] addWrap(input logic [15:0] base, input logic [15:0] off);
        addWrap = base + off; // RULE25
    endfunction

    always_comb begin
        eaNext = 16'h0000;
        unique case (eaMode)
            register_only_mode:             eaNext = 16'h0000;
            branch_offset_mode:             eaNext = addWrap(pc_reg,
                                                {{8{operandLo[7]}}, operandLo}); // RULE4
            literal_operand_mode:           eaNext = pc_reg; // RULE5
            page_zero_mode:                 eaNext = {PAGE_ZERO_HI, operandLo}; // RULE6
            full_address_mode:              eaNext = {operandHi, operandLo}; // RULE7
            index_no_offset_mode,
            index_postinc_mode:             eaNext = ix_reg; // RULE8
            index_byte_offset_mode,
            index_byte_offset_postinc_mode: eaNext = addWrap(ix_reg, {8'h00, operandLo}); // RULE10
            index_word_offset_mode:         eaNext = addWrap(ix_reg,
                                                {operandHi, operandLo}); // RULE11
            stack_byte_offset_mode:         eaNext = addWrap(sp_reg, {8'h00, operandLo}); // RULE12
            stack_word_offset_mode:         eaNext = addWrap(sp_reg,
                                                {operandHi, operandLo}); // RULE13
            default:                        eaNext = 16'h0000;
        endcase
    end

    assign postInc = eaStart && (eaMode == index_postinc_mode ||
                                 eaMode == index_byte_offset_postinc_mode);

    // branch target uses its own offset path; the operand mode only locates the tested byte
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            operandAddr  <= 16'h0000;
            operandValid <= 1'b0;
            operandNoMem <= 1'b0;
            literalWord  <= 16'h0000;
        end else begin
            operandValid <= eaStart && eaMode != register_only_mode && eaMode != branch_offset_mode;
            operandNoMem <= eaStart && eaMode == register_only_mode; // RULE3
            if (eaStart && eaMode != branch_offset_mode) begin
                operandAddr <= eaNext; // RULE1 RULE2
            end
            if (eaStart && eaMode == literal_operand_mode) begin
                literalWord <= {operandHi, operandLo}; // RULE5
            end
        end
    end

    // the hold off is armed only when the mask really was set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqBlock_reg <= 1'b0;
        end else if (maskClearOp && flags_reg[MASK_BIT]) begin
            irqBlock_reg <= 1'b1; // RULE24
        end else if (instrBoundary) begin
            irqBlock_reg <= 1'b0;
        end
    end

    assign irqTake = seqState_reg == S_IDLE && !dbg_reg && lp_reg != LP_HALT &&
                     ((instrBoundary && irqPending && !flags_reg[MASK_BIT] && !irqBlock_reg)
                      || trapOp); // RULE16 RULE19
    assign wake = irqPending && !flags_reg[MASK_BIT];

    // reset wins over everything, so no boundary is awaited
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            seqState_reg <= S_RST; // RULE14
            stepCnt_reg  <= 3'd0;
            vecAddr_reg  <= RESET_VECTOR_HI;
            vecHi_reg    <= 8'h00;
        end else begin
            unique case (seqState_reg)
                S_IDLE: begin
                    if (irqTake || (lp_reg == LP_DOZE && wake)) begin
                        seqState_reg <= S_PUSH;
                        stepCnt_reg  <= 3'd0;
                        vecAddr_reg  <= trapOp ? irqVectorAddr : irqVectorAddr; // RULE16
                    end
                end
                S_RST: begin
                    stepCnt_reg <= stepCnt_reg + 3'd1;
                    if (stepCnt_reg == 3'd0) begin
                        vecHi_reg <= memRdata;
                    end
                    if (stepCnt_reg == 3'(RESET_SEQ_CYCLES - 1)) begin
                        seqState_reg <= S_IDLE; // RULE15
                    end
                end
                S_PUSH: begin
                    stepCnt_reg <= stepCnt_reg + 3'd1;
                    if (stepCnt_reg == 3'd4) begin
                        seqState_reg <= S_VEC_HI;
                    end
                end
                S_VEC_HI: begin
                    vecHi_reg    <= memRdata;
                    seqState_reg <= S_VEC_LO;
                end
                S_VEC_LO: seqState_reg <= S_FREE;
                S_FREE: begin
                    seqState_reg <= S_FETCH;
                    stepCnt_reg  <= 3'd0;
                end
                S_FETCH: begin
                    stepCnt_reg <= stepCnt_reg + 3'd1;
                    if (stepCnt_reg == 3'(PREFETCH_BYTES - 1)) begin
                        seqState_reg <= S_IDLE; // RULE17
                    end
                end
                default: seqState_reg <= S_IDLE;
            endcase
        end
    end

    // bus drive: stacking order pcl, pch, x, a, flags; upper index byte never stacked
    always_comb begin
        memAddr  = operandAddr;
        memRead  = operandValid;
        memWrite = 1'b0;
        memWdata = 8'h00;
        unique case (seqState_reg)
            S_IDLE: begin
            end
            S_RST: begin
                memAddr = (stepCnt_reg == 3'd0) ? RESET_VECTOR_HI :
                          (stepCnt_reg == 3'd1) ? RESET_VECTOR_LO : pc_reg; // RULE15
                memRead = stepCnt_reg != 3'd2;
            end
            S_PUSH: begin
                memAddr  = sp_reg;
                memRead  = 1'b0;
                memWrite = 1'b1;
                unique case (stepCnt_reg)
                    3'd0:    memWdata = pc_reg[7:0];
                    3'd1:    memWdata = pc_reg[15:8];
                    3'd2:    memWdata = ix_reg[7:0]; // RULE18
                    3'd3:    memWdata = accIn;
                    default: memWdata = flags_reg; // RULE17
                endcase
            end
            S_VEC_HI: begin
                memAddr = vecAddr_reg;
                memRead = 1'b1; // RULE17
            end
            S_VEC_LO: begin
                memAddr = addWrap(vecAddr_reg, INDEX_STEP);
                memRead = 1'b1;
            end
            S_FREE:   memRead = 1'b0;
            S_FETCH: begin
                memAddr = pc_reg;
                memRead = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pc_reg <= 16'h0000;
        end else if (seqState_reg == S_RST && stepCnt_reg == 3'd1) begin
            pc_reg <= {vecHi_reg, memRdata};
        end else if (seqState_reg == S_VEC_LO) begin
            pc_reg <= {vecHi_reg, memRdata};
        end else if ((seqState_reg == S_RST && stepCnt_reg > 3'd2) || seqState_reg == S_FETCH) begin
            pc_reg <= pc_reg + INDEX_STEP;
        end else if (eaStart && eaMode == branch_offset_mode && branchTaken) begin
            pc_reg <= eaNext; // RULE4 RULE2
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sp_reg <= STACK_RESET; // RULE23
        end else if (seqState_reg == S_PUSH) begin
            sp_reg <= sp_reg - INDEX_STEP;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ix_reg <= 16'h0000;
        end else if (postInc) begin
            ix_reg <= addWrap(ix_reg, INDEX_STEP); // RULE9
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flags_reg <= FLAGS_RESET;
        end else if (seqState_reg == S_PUSH && stepCnt_reg == 3'd4) begin
            flags_reg[MASK_BIT] <= 1'b1; // RULE17
        end else if (dozeOp || maskClearOp) begin
            flags_reg[MASK_BIT] <= 1'b0; // RULE20
        end
    end

    // low-power and debug state; debug command wakes doze, and wakes halt only with a debug host attached and debug enabled
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lp_reg  <= LP_RUN;
            dbg_reg <= 1'b0;
        end else begin
            // a halted part only hears the host while its oscillator is kept alive
            if (dbgCmd == CMD_DEBUG_HALT && (lp_reg == LP_DOZE ||
                    (lp_reg == LP_HALT && debugHostAttached && debug_enable_bit))) begin
                lp_reg  <= LP_RUN; // RULE20 RULE21
                dbg_reg <= 1'b1;
            end else if (lp_reg == LP_DOZE && wake) begin
                lp_reg <= LP_RUN; // RULE20
            end else if (dozeOp && seqState_reg == S_IDLE) begin
                lp_reg <= LP_DOZE;
            end else if (haltOp && seqState_reg == S_IDLE) begin
                lp_reg <= LP_HALT;
            end
            if (debugHaltOp) begin
                dbg_reg <= 1'b1; // RULE22
            end else if (dbg_reg && (dbgCmd == CMD_RESUME || dbgCmd == CMD_SINGLE_STEP ||
                                     dbgCmd == CMD_TAGGED_RESUME)) begin
                dbg_reg <= 1'b0; // RULE22
            end
        end
    end

    // debug mode keeps the cpu clocked so host commands can be served
    assign cpuClockEnable = lp_reg == LP_RUN; // RULE20 RULE21
    assign oscKeepAlive   = debugHostAttached && debug_enable_bit; // RULE21
    assign debugActive    = dbg_reg;
    assign seqBusy        = seqState_reg != S_IDLE;
    assign programCounter = pc_reg;
    assign stack_pointer  = sp_reg;
    assign indexPair      = ix_reg;
    assign flag_register  = flags_reg;
endmodule

// File: cag_core_props.sv
// assertions on cag_core ports: address forming, reset fetch, stack reset
// assumes binding to cag_core with one clock and a synchronous reset
`timescale 1ns/1ns
module cag_core_props (
    input wire logic                  core_clk,
    input wire logic                  sys_rst,
    input wire logic                  eaStart,
    input wire cag_pkg::cag_mode_type eaMode,
    input wire logic [7:0]            operandHi,
    input wire logic [7:0]            operandLo,
    input wire logic [15:0]           memAddr,
    input wire logic                  memRead,
    input wire logic                  memWrite,
    input wire logic [15:0]           operandAddr,
    input wire logic                  operandValid,
    input wire logic                  operandNoMem,
    input wire logic [15:0]           stack_pointer,
    input wire logic [15:0]           indexPair,
    input wire logic                  seqBusy
);
    import cag_pkg::*;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_page_zero_addr: assert property (
        eaStart && eaMode == page_zero_mode |=> operandAddr == {8'h00, $past(operandLo)})
        else $error("page zero address wrong");
    a_index_direct: assert property (
        eaStart && eaMode == index_no_offset_mode |=> operandValid && operandAddr == $past(indexPair))
        else $error("index address wrong");
    a_postinc_step: assert property (
        eaStart && eaMode == index_postinc_mode |=> indexPair == $past(indexPair) + 16'h0001)
        else $error("index not stepped");
    a_byte_offset: assert property (
        eaStart && eaMode == index_byte_offset_mode
        |=> operandAddr == $past(indexPair) + {8'h00, $past(operandLo)})
        else $error("index byte offset wrong");
    a_stack_word: assert property (
        eaStart && eaMode == stack_word_offset_mode
        |=> operandAddr == $past(stack_pointer) + {$past(operandHi), $past(operandLo)})
        else $error("stack word offset wrong");
    a_no_mem_fetch: assert property (
        eaStart && eaMode == register_only_mode |=> operandNoMem && !operandValid)
        else $error("register-only mode fetched");
    a_reset_vector: assert property (
        $fell(sys_rst) |-> (memRead && memAddr == 16'hfffe) ##1 (memRead && memAddr == 16'hffff))
        else $error("reset vector fetch wrong");
    a_reset_length: assert property (
        $fell(sys_rst) |-> seqBusy [*6] ##1 !seqBusy)
        else $error("reset sequence length wrong");
    // reset itself is the cause here, so this one is never disabled
    a_reset_abandon: assert property (disable iff (1'h0)
        sys_rst |=> !memWrite && stack_pointer == 16'h00ff)
        else $error("reset did not abandon activity");
    c_postinc: cover property (eaStart && eaMode == index_postinc_mode);
    c_reset_seq: cover property ($fell(sys_rst) ##6 !seqBusy);
    c_push: cover property (memWrite [*5]);
endmodule

// File: cag_mem_model.sv
// memory model answering core reads with a byte derived from the address
// assumes read data is wanted in the same cycle as the address
`timescale 1ns/1ns
module cag_mem_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] memAddr,
    input  wire logic        memRead,
    output logic [7:0]       memRdata
);
    logic [7:0] lastByte_reg;
    // an idle bus shows the inverse of the last byte so stale data never looks valid
    assign memRdata = memRead ? (memAddr[15:8] ^ memAddr[7:0] ^ 8'h5a) : ~lastByte_reg;
    always_ff @(posedge core_clk) begin
        if (memRead) begin
            lastByte_reg <= memRdata;
        end
    end
endmodule

// File: cag_core_tb.sv
// bench for cag_core: address modes, reset fetch, stacking, low power, debug
// assumes cag_mem_model on the bus; accIn and irqVectorAddr are held constant
`timescale 1ns/1ns
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin errCount++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module cag_core_tb;
    import cag_pkg::*;
    logic            core_clk = 1'h0;
    logic            sys_rst = 1'h1;
    logic            eaStart = 1'h0;
    logic            branchTaken = 1'h0;
    logic            irqPending = 1'h0;
    logic            debugHostAttached = 1'h0;
    logic            debug_enable_bit = 1'h0;
    logic [5:0]      ops = 6'h0;
    cag_mode_type    eaMode = register_only_mode;
    cag_dbg_cmd_type dbgCmd = CMD_NONE;
    logic [7:0]      operandHi = 8'h0;
    logic [7:0]      operandLo = 8'h0;
    logic [7:0]      accIn = 8'h3c;
    logic [15:0]     irqVectorAddr = 16'h2400;
    logic [7:0]      memRdata, memWdata, flag_register;
    logic [15:0]     memAddr, operandAddr, literalWord, programCounter, stack_pointer, indexPair;
    logic            memRead, memWrite, operandValid, operandNoMem;
    logic            cpuClockEnable, oscKeepAlive, debugActive, seqBusy;
    wire             trapOp = ops[0], dozeOp = ops[1], haltOp = ops[2];
    wire             debugHaltOp = ops[3], maskClearOp = ops[4], instrBoundary = ops[5];
    int              errCount = 0;
    int              samplesChecked = 0;
    logic [15:0]     wa[$], ra[$];
    logic [7:0]      wd[$];

    cag_core dut_u (.*);
    cag_mem_model mem_u (.core_clk(core_clk), .memAddr(memAddr), .memRead(memRead),
        .memRdata(memRdata));

    always #20 core_clk = ~core_clk;

    function automatic logic [7:0] mv(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction

    task automatic endSim;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic pulse(input logic [5:0] v);
        @(posedge core_clk);
        ops <= v;
        @(posedge core_clk);
        ops <= 6'h0;
    endtask

    task automatic cmd(input cag_dbg_cmd_type c);
        @(posedge core_clk);
        dbgCmd <= c;
        @(posedge core_clk);
        dbgCmd <= CMD_NONE;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // bus cycles are sampled mid-cycle, where the combinational drive has settled
    task automatic grab;
        wa.delete();
        wd.delete();
        ra.delete();
        repeat (30) begin
            @(negedge core_clk);
            if (memWrite) begin
                wa.push_back(memAddr);
                wd.push_back(memWdata);
            end
            if (memRead && seqBusy) ra.push_back(memAddr);
        end
    endtask

    task automatic ea(input cag_mode_type m, input logic [15:0] op, input logic bt);
        @(posedge core_clk);
        eaStart <= 1'h1;
        eaMode <= m;
        {operandHi, operandLo} <= op;
        branchTaken <= bt;
        @(posedge core_clk);
        eaStart <= 1'h0;
        branchTaken <= 1'h0;
        #1;
    endtask

    task automatic t_reset;
        @(posedge core_clk);
        sys_rst <= 1'h1;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("rstwr", 1'h0, memWrite)
        `CHK("rstsp", 16'h00ff, stack_pointer)
        @(posedge core_clk);
        sys_rst <= 1'h0;
        grab;
        `CHK("rstrd0", 16'hfffe, ra[0])
        `CHK("rstrd1", 16'hffff, ra[1])
        `CHK("rstnrd", 5, ra.size())
        `CHK("rstpc", {mv(16'hfffe), mv(16'hffff)} + 16'h3, programCounter)
        `CHK("rstfl", {16'h0, 8'h68}, {indexPair, flag_register})
    endtask

    task automatic t_modes;
        cag_mode_type m[9] = '{index_postinc_mode, index_no_offset_mode,
            index_byte_offset_postinc_mode, index_byte_offset_mode, index_word_offset_mode,
            stack_byte_offset_mode, stack_word_offset_mode, page_zero_mode, full_address_mode};
        logic [15:0] op[9] = '{16'h0, 16'h0, 16'hf0, 16'hff, 16'hffff, 16'h80, 16'hff10,
            16'h1234, 16'h1234};
        logic [15:0] ad[9] = '{16'h0, 16'h1, 16'hf1, 16'h101, 16'h1, 16'h17f, 16'hf,
            16'h34, 16'h1234};
        logic [15:0] ix[9] = '{16'h1, 16'h1, 16'h2, 16'h2, 16'h2, 16'h2, 16'h2, 16'h2, 16'h2};
        logic [15:0] pc;
        foreach (m[i]) begin
            ea(m[i], op[i], 1'h0);
            `CHK(m[i].name(), ad[i], operandAddr)
            `CHK("valid", 1'h1, operandValid)
            `CHK("ix", ix[i], indexPair)
        end
        ea(literal_operand_mode, 16'habcd, 1'h0);
        `CHK("lit", 16'habcd, literalWord)
        ea(register_only_mode, 16'h0, 1'h0);
        `CHK("nomem", 2'h2, {operandNoMem, operandValid})
        pc = programCounter;
        ea(branch_offset_mode, 16'h00f0, 1'h1);
        `CHK("branch", pc + 16'hfff0, programCounter)
    endtask

    task automatic run_seq(input logic [5:0] v, input logic irq, input logic [7:0] fl);
        logic [15:0] pc0, sp0;
        logic [7:0]  ex[5];
        pc0 = programCounter;
        sp0 = stack_pointer;
        ex = '{pc0[7:0], pc0[15:8], indexPair[7:0], accIn, fl};
        @(posedge core_clk);
        irqPending <= irq;
        ops <= v;
        @(posedge core_clk);
        ops <= 6'h0;
        grab;
        @(posedge core_clk);
        irqPending <= 1'h0;
        `CHK("npush", 5, wa.size())
        foreach (ex[i]) `CHK("push", {sp0 - 16'(i), ex[i]}, {wa[i], wd[i]})
        `CHK("mask", 1'h1, flag_register[MASK_BIT])
        if (irq) begin
            `CHK("vec", irqVectorAddr, ra[0])
            `CHK("nread", 5, ra.size())
            `CHK("pc", {mv(irqVectorAddr), mv(irqVectorAddr + 16'h1)} + 16'h3, programCounter)
        end
    endtask

    task automatic t_irq;
        @(posedge core_clk);
        irqPending <= 1'h1;
        pulse(6'h10);
        pulse(6'h20);
        cmd(CMD_NONE);
        `CHK("holdoff", 1'h0, seqBusy)
        run_seq(6'h20, 1'h1, 8'h60);
        run_seq(6'h01, 1'h0, 8'h68);
        pulse(6'h02);
        cmd(CMD_NONE);
        `CHK("doze", 2'h0, {cpuClockEnable, flag_register[MASK_BIT]})
        run_seq(6'h00, 1'h1, 8'h60);
        `CHK("wake", 1'h1, cpuClockEnable)
    endtask

    task automatic t_dbg;
        cag_dbg_cmd_type r[3] = '{CMD_RESUME, CMD_SINGLE_STEP, CMD_TAGGED_RESUME};
        foreach (r[i]) begin
            pulse(6'h08);
            cmd(CMD_NONE);
            `CHK("debug_halt_opcode", 1'h1, debugActive)
            cmd(r[i]);
            `CHK(r[i].name(), 1'h0, debugActive)
        end
        @(posedge core_clk);
        debugHostAttached <= 1'h1;
        debug_enable_bit <= 1'h1;
        pulse(6'h04);
        cmd(CMD_NONE);
        `CHK("halt", 2'h2, {oscKeepAlive, cpuClockEnable})
        cmd(CMD_DEBUG_HALT);
        `CHK("hwake", 2'h3, {debugActive, cpuClockEnable})
        cmd(CMD_RESUME);
        pulse(6'h02);
        cmd(CMD_DEBUG_HALT);
        `CHK("dwake", 2'h3, {debugActive, cpuClockEnable})
        cmd(CMD_RESUME);
    endtask

    initial begin
        t_reset;
        $display("reset test done");
        t_modes;
        $display("mode test done");
        t_irq;
        $display("stacking test done");
        t_dbg;
        $display("debug test done");
        // a trap cut short by reset has already pushed pcl and pch; reset must stop the writes and reload the stack pointer
        pulse(6'h01);
        t_reset;
        $display("abort test done");
        endSim;
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        errCount++;
        endSim;
    end
endmodule

bind cag_core cag_core_props chk_u (.*);
